// ==== core/srec_ctrl.sv ====
`timescale 1ns/1ps
// Function
// - Writing busy one runs the selected command at the stored address.
// - Busy stays set until the operation ends; then read data are valid.
// - Failed write with no part attached clears busy only on time-out.
// - Busy set at reset, cleared after the station address load attempt.
// - Three-bit command runs only with busy set; one command at a time.
module srec_ctrl #(
    parameter int TIMEOUT_CYC = srec_pkg::SREC_TIMEOUT_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic op_start_out,
    output logic [2:0] op_cmd_out,
    output logic [7:0] op_addr_out,
    output logic [31:0] op_wdata_out,
    output logic autoload_out,
    input wire logic op_done_in,
    input wire logic [31:0] op_rdata_in,
    input wire logic op_rdata_valid_in
);
    import srec_pkg::*;

    // ========================================
    // Sequencer and register state
    srec_state_e state_q;
    logic busy_q;
    logic autoload_q;
    logic start_q;
    logic timeout_q;
    logic [2:0] cmd_q;
    logic [7:0] addr_q;
    logic [31:0] data_q;

    // ========================================
    // Decodes, time-out and read word
    logic expired;
    logic finish;
    logic wr_cmd;
    logic wr_data;
    logic launch;
    logic [31:0] rd_word;

    // ========================================
    // Bus decode
    assign wr_cmd = reg_wr_in && (reg_addr_in == SREC_CMD_CTRL_OFS);
    assign wr_data = reg_wr_in && (reg_addr_in == SREC_DATA_WORD_OFS);
    assign launch = wr_cmd && !busy_q && reg_wdata_in[SREC_BUSY_BIT];

    // ========================================
    // Time-out counter
    // counts only in the wait state; a missing part would
    // otherwise hold busy forever and lock software out
    srec_timer #(
        .LIMIT(TIMEOUT_CYC)
    ) u_timer (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .run_in(state_q == SREC_ST_WAIT),
        .expired_out(expired)
    );

    // ========================================
    // Command code
    // writes ignored while busy so a running command keeps its code
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            cmd_q <= SREC_CMD_RST;
        end
        else if (wr_cmd && !busy_q)
        begin
            cmd_q <= reg_wdata_in[SREC_CMD_LSB +: SREC_CMD_W];
        end
    end

    // ========================================
    // Target address
    // frozen while busy; only the low byte is kept
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            addr_q <= SREC_ADDR_RST;
        end
        else if (wr_cmd && !busy_q)
        begin
            addr_q <= reg_wdata_in[SREC_ADDR_W-1:0];
        end
    end

    // ========================================
    // Data word: host writes when idle, engine loads read data
    // Engine data win a tie; a host write while busy is dropped
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            data_q <= SREC_DATA_RST;
        end
        else if (op_rdata_valid_in)
        begin
            data_q <= op_rdata_in;
        end
        else if (wr_data && !busy_q)
        begin
            data_q <= reg_wdata_in;
        end
    end

    // ========================================
    // Operation end: engine done or time-out; a tie counts as done
    assign finish = (state_q == SREC_ST_WAIT) && (op_done_in || expired);

    // ========================================
    // Sequencer state
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            // autoload starts straight out of reset
            state_q <= SREC_ST_RUN;
        end
        else
        begin
            unique case (state_q)
                SREC_ST_IDLE:
                begin
                    if (launch)
                    begin
                        state_q <= SREC_ST_RUN;
                    end
                end
                SREC_ST_RUN:
                begin
                    // One cycle for the engine to take the start pulse
                    state_q <= SREC_ST_WAIT;
                end
                SREC_ST_WAIT:
                begin
                    if (finish)
                    begin
                        state_q <= SREC_ST_IDLE;
                    end
                end
                default:
                begin
                    // Unused code: recover to idle
                    state_q <= SREC_ST_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // Busy flag; only reset or a software launch sets it
    // Launch is refused while busy, so a second write cannot restart a command
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            busy_q <= 1'b1;
        end
        else if (finish)
        begin
            busy_q <= 1'b0;
        end
        else if (launch && (state_q == SREC_ST_IDLE))
        begin
            busy_q <= 1'b1;
        end
        // Unused state code: release busy so software is not locked out
        else if (!(state_q inside {SREC_ST_IDLE, SREC_ST_RUN, SREC_ST_WAIT}))
        begin
            busy_q <= 1'b0;
        end
    end

    // ========================================
    // Autoload marker, high only for the load after reset
    // Cleared by the first finish, whether the load worked or timed out
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            autoload_q <= 1'b1;
        end
        else if (finish)
        begin
            autoload_q <= 1'b0;
        end
    end

    // ========================================
    // Start pulse to the serial engine
    // Reset forces it high so the autoload needs no software help
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            start_q <= 1'b1;
        end
        else
        begin
            start_q <= launch && (state_q == SREC_ST_IDLE);
        end
    end

    // ========================================
    // Time-out flag; sticky until next launch, done wins a tie
    // Kept after busy clears so software can tell failure from success
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            timeout_q <= 1'b0;
        end
        else if (state_q == SREC_ST_WAIT && expired && !op_done_in)
        begin
            timeout_q <= 1'b1;
        end
        else if (launch)
        begin
            timeout_q <= 1'b0;
        end
    end

    // ========================================
    // Read multiplexer; unmapped offsets read as zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (reg_addr_in)
            SREC_CMD_CTRL_OFS:
            begin
                // Busy, command and address share one word
                rd_word = {busy_q, cmd_q, 20'h0_0000, addr_q};
            end
            SREC_DATA_WORD_OFS:
            begin
                // Last read result or last host word
                rd_word = data_q;
            end
            SREC_STATUS_OFS:
            begin
                rd_word = {22'h0, timeout_q, 9'h000};
            end
            default:
            begin
                // Unmapped offset
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ========================================
    // Read port, one cycle latency
    // Data stand only for the cycle after the strobe, zero otherwise,
    // so a stale word can never be taken for a fresh answer
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
        else if (reg_rd_in)
        begin
            reg_rdata_out <= rd_word;
        end
        else
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

    // ========================================
    // Engine interface
    assign op_start_out = start_q;
    assign op_cmd_out = cmd_q;
    assign op_addr_out = addr_q;
    assign op_wdata_out = data_q;
    assign autoload_out = autoload_q;
endmodule // srec_ctrl

// ==== core/srec_pkg.sv ====
package srec_pkg;

    // ========================================
    // Register map
    localparam logic [7:0] SREC_CMD_CTRL_OFS = 8'hB0;
    localparam logic [7:0] SREC_DATA_WORD_OFS = 8'hB4;
    localparam logic [7:0] SREC_STATUS_OFS = 8'hB8;

    // ========================================
    // Field positions in the command/control register; the time-out bit is in the status register
    localparam int SREC_BUSY_BIT = 31;
    localparam int SREC_CMD_LSB = 28;
    localparam int SREC_CMD_W = 3;
    localparam int SREC_ADDR_W = 8;
    localparam int SREC_TIMEOUT_BIT = 9;

    // ========================================
    // Reset values
    localparam logic [2:0] SREC_CMD_RST = 3'h0;
    localparam logic [7:0] SREC_ADDR_RST = 8'h00;
    localparam logic [31:0] SREC_DATA_RST = 32'h0000_0000;

    // ========================================
    // Timing
    localparam int SREC_CLK_HZ = 40_000_000;
    localparam int SREC_TIMEOUT_US = 30_000;
    localparam int SREC_TIMEOUT_CYC = SREC_TIMEOUT_US * (SREC_CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        SREC_ST_IDLE = 2'b00,
        SREC_ST_RUN = 2'b01,
        SREC_ST_WAIT = 2'b10
    } srec_state_e;

endpackage

// ==== core/srec_timer.sv ====
`timescale 1ns/1ps
module srec_timer #(
    parameter int LIMIT = 1200000
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic run_in,
    output logic expired_out
);
    logic [31:0] count_q;

    // ========================================
    // Counts while run is high, restarts when it drops
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || !run_in)
        begin
            count_q <= 32'h0000_0000;
        end
        else if (count_q != LIMIT[31:0])
        begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    assign expired_out = run_in && (count_q == LIMIT[31:0]);
endmodule // srec_timer

// ==== tb/serial_eeprom_command_tb.sv ====
`timescale 1ns/1ps
module serial_eeprom_command_tb;
    import srec_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic off = 1'b0;
    logic op_start_out, autoload_out, op_done_in, op_rdata_valid_in;
    logic [2:0] op_cmd_out;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] op_addr_out;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [31:0] reg_rdata_out, op_rdata_in, d, wd;
    int err_count = 0;
    int checks = 0;
    always #12.5 clk_sys_in = ~clk_sys_in;
    srec_ctrl #(.TIMEOUT_CYC(20)) dut (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .op_start_out, .op_cmd_out, .op_addr_out,
        .op_wdata_out(wd), .autoload_out, .op_done_in, .op_rdata_in, .op_rdata_valid_in);
    srec_engine_model model (.clk_sys_in, .rst_in, .start_in(op_start_out),
        .cmd_in(op_cmd_out), .addr_in(op_addr_out), .absent_in(off),
        .done_out(op_done_in), .rvalid_out(op_rdata_valid_in), .rdata_out(op_rdata_in));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] v = 32'h0);
        @(posedge clk_sys_in);
        reg_wr_in <= w;
        reg_rd_in <= !w;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    // Bounded poll; a stuck busy shows as a mismatch and ends the run
    // host writes nothing until busy reads clear
    task idle;
        bus(1'b0, SREC_CMD_CTRL_OFS);
        repeat (60)
            if (d[31] !== 1'b0)
                bus(1'b0, SREC_CMD_CTRL_OFS);
        chk(d & 32'h8000_0000, 32'h0);
        if (d[31] !== 1'b0)
            stop_test;
    endtask
    task t_reset;
        bus(1'b0, SREC_CMD_CTRL_OFS);
        chk(d & 32'h8000_0000, 32'h8000_0000);
        idle;
    endtask
    task t_cmds;
        logic [31:0] v;
        for (int c = 0; c < 8; c++)
        begin
            v = {1'b1, 3'(c), 20'h0, 8'(c + 16)};
            bus(1'b1, SREC_CMD_CTRL_OFS, v);
            // Early rewrite while busy must be dropped
            bus(1'b1, SREC_CMD_CTRL_OFS, 32'h0000_0055);
            bus(1'b0, SREC_CMD_CTRL_OFS);
            chk(d, v);
            idle;
            bus(1'b0, SREC_DATA_WORD_OFS);
            if (c == 0)
                chk(d, {24'hA5C3E1, v[7:0]});
        end
    endtask
    task t_timeout;
        off <= 1'b1;
        bus(1'b1, SREC_CMD_CTRL_OFS, 32'hB000_0033);
        repeat (8) @(posedge clk_sys_in);
        bus(1'b0, SREC_CMD_CTRL_OFS);
        chk(d, 32'hB000_0033);
        idle;
        repeat (4) @(posedge clk_sys_in);
        bus(1'b0, SREC_STATUS_OFS);
        chk(d & 32'h200, 32'h200);
        bus(1'b0, SREC_CMD_CTRL_OFS);
        chk(d, 32'h3000_0033);
        off <= 1'b0;
        bus(1'b1, SREC_CMD_CTRL_OFS, 32'h8000_0001);
        idle;
        bus(1'b0, SREC_STATUS_OFS);
        chk(d & 32'h200, 32'h0);
        bus(1'b0, 8'hC0);
        chk(d, 32'h0);
        bus(1'b1, SREC_DATA_WORD_OFS, 32'h1234_5678);
        chk(wd, 32'h1234_5678);
        bus(1'b0, SREC_DATA_WORD_OFS);
        chk(d, 32'h1234_5678);
    endtask
    initial
    begin
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_reset;
        t_cmds;
        t_timeout;
        stop_test;
    end
endmodule // serial_eeprom_command_tb

// ==== tb/srec_ctrl_monitor.sv ====
`timescale 1ns/1ps
module srec_ctrl_monitor #(
    parameter int TIMEOUT_CYC = 20
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic op_start_out,
    input wire logic [2:0] op_cmd_out,
    input wire logic autoload_out,
    input wire logic op_done_in
);
    import srec_pkg::*;
    logic [7:0] age_q;
    logic rd_cmd;
    assign rd_cmd = reg_rd_in && reg_addr_in == SREC_CMD_CTRL_OFS;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // Saturating age of the pending operation
    always_ff @(posedge clk_sys_in)
        age_q <= (rst_in || op_done_in) ? 8'h00 : op_start_out ? 8'h01 :
            age_q + {7'h00, age_q != 8'h00 && age_q != 8'hFF};
    AST_LAUNCH: assert property (op_start_out && !autoload_out |->
        op_cmd_out == $past(reg_wdata_in[30:28])) else $error("launch");
    AST_DONE: assert property ($past(op_done_in) && rd_cmd |=> !reg_rdata_out[31])
        else $error("done");
    AST_RESET: assert property ($fell(rst_in) |-> autoload_out && op_start_out)
        else $error("autoload");
    AST_HOLD: assert property (rd_cmd && age_q != 8'h00 && age_q < TIMEOUT_CYC |=>
        reg_rdata_out[31]) else $error("hold");
    AST_TO_CLR: assert property (rd_cmd && age_q > TIMEOUT_CYC + 4 |=>
        !reg_rdata_out[31]) else $error("stuck");
    AST_TO_FLAG: assert property (reg_rd_in && reg_addr_in == SREC_STATUS_OFS &&
        age_q > TIMEOUT_CYC + 4 |=> reg_rdata_out[SREC_TIMEOUT_BIT]) else $error("flag");
    cover property (op_start_out && !autoload_out);
    cover property (op_done_in);
    cover property (age_q > TIMEOUT_CYC + 4);
endmodule // srec_ctrl_monitor
bind srec_ctrl srec_ctrl_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (.clk_sys_in, .rst_in,
    .reg_addr_in, .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .op_start_out, .op_cmd_out,
    .autoload_out, .op_done_in);

// ==== tb/srec_engine_model.sv ====
`timescale 1ns/1ps
module srec_engine_model (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [2:0] cmd_in,
    input wire logic [7:0] addr_in,
    input wire logic absent_in,
    output logic done_out,
    output logic rvalid_out,
    output logic [31:0] rdata_out
);
    logic [2:0] cnt_q;
    // Idle bus shows the inverse so stale data never looks fresh
    assign rdata_out = {24'hA5C3E1, addr_in} ^ {32{!rvalid_out}};
    always_ff @(posedge clk_sys_in)
    begin
        done_out <= cnt_q == 3'h1;
        rvalid_out <= cnt_q == 3'h1 && cmd_in == 3'h0;
        if (rst_in || (start_in && absent_in))
            cnt_q <= 3'h0;
        else if (start_in)
            cnt_q <= 3'h6;
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end
endmodule // srec_engine_model
